// ### option_defs.vh
// offsets, field positions, reset values and flash addresses of the option and trim loader
`ifndef OPTION_DEFS_VH
`define OPTION_DEFS_VH
`define REG_TRIM_INDEX 8'h00
`define REG_TRIM_DATA 8'h04
`define REG_OPT_PROTECT 8'h08
`define REG_OPT_OSC 8'h0c
`define REG_STATUS 8'h10
`define REG_SERIAL 8'h14
`define BIT_WRITE_PROTECT 0
`define BIT_MUST_BE_ONE 1
`define BIT_READ_PROTECT 2
`define BIT_BO_ALWAYS_ON 3
`define BIT_XTAL_DISABLE 4
`define BIT_RP_HONOURED 5
`define STAT_READY 0
`define STAT_BLOCKED 1
`define STAT_BIT1_BAD 2
`define TRIM_LAST 8'h1f
`define TRIM_INFO_BASE 7'h20
`define SERIAL_INFO_BASE 7'h7c
`define OPT_PROTECT_ADDR 13'h0000
`define OPT_OSC_ADDR 13'h0001
`define STEP_OPT_OSC 6'd1
`define STEP_TRIM_FIRST 6'd2
`define STEP_SERIAL_FIRST 6'd34
`define STEP_LAST 6'd37
`define ERASED_BYTE 8'hff
`define TRIM_INDEX_RESET 8'h00
`define PAGE_ZERO 4'h0
`endif

// ### trim_store.v
// working copies of the 32 trim bytes
`timescale 1ns/1ps
`default_nettype none
module trim_store (
  // clock
  input wire pclk,
  // factory reload
  input wire load_en,
  input wire [4:0] load_index,
  input wire [7:0] load_data,
  // software write
  input wire wr_en,
  input wire [4:0] wr_index,
  input wire [7:0] wr_data,
  // software read
  input wire [4:0] rd_index,
  output wire [7:0] rd_data
);
  reg [7:0] mem [0:31];

  always @(posedge pclk) begin
    if (load_en) begin
      mem[load_index] <= load_data; // R4
    end else if (wr_en) begin
      mem[wr_index] <= wr_data; // R2
    end
  end

  assign rd_data = mem[rd_index]; // R3
endmodule
`default_nettype wire

// ### option_trim_config.v
// option byte latch, trim window, serial number and flash protection gate
//
// Functional notes
// R1 - option bytes live in program bytes 0,1
// R2 - trim index then data write updates copy
// R3 - trim index then data read returns copy
// R4 - working trim reverts to factory on reset
// R5 - factory trim never written by this block
// R6 - indirect path reaches info 20-3F only
// R7 - calibration bytes read by software constant load
// R8 - four-byte serial number held per device
// R9 - bit3 zero allows stop-mode brown-out off
// R10 - bit2 zero hides code, limits debugger
// R11 - programmer keeps option bit1 at one
// R12 - bit0 zero blocks user program/erase
// R13 - bit0 one permits program and erase
// R14 - oscillator byte bit4 crystal disable, reset-kept
// R15 - debug status bit5 reports protect honoured
// R16 - option bytes latched before user code runs
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "option_defs.vh"
module option_trim_config (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // flash read port, one cycle latency
  output reg flash_rd_en,
  output reg flash_info_sel,
  output reg [12:0] flash_addr,
  input wire [7:0] flash_rdata,
  // flash write requests from user code and debugger
  input wire user_prog_req,
  input wire user_page_erase_req,
  input wire [3:0] erase_page,
  input wire user_mass_erase_req,
  input wire debug_mass_erase_req,
  output reg prog_grant,
  output reg page_erase_grant,
  output reg mass_erase_grant,
  // power and debug context
  input wire stop_mode,
  input wire brownout_off_request,
  input wire read_protect_honoured,
  // configuration outputs
  output reg config_ready,
  output reg brownout_always_on,
  output reg brownout_enable,
  output reg code_read_protect,
  output reg debug_full_access,
  output reg code_write_protect,
  output reg crystal_disable_option
);
  localparam ST_ISSUE = 2'b00;
  localparam ST_WAIT = 2'b01;
  localparam ST_TAKE = 2'b10;
  localparam ST_DONE = 2'b11;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [5:0] step;
  reg [7:0] opt_protect;
  reg [7:0] opt_osc;
  reg [31:0] serial;
  reg [7:0] trim_index;
  reg blocked;
  wire [7:0] trim_rd_data;
  wire trim_load_en;
  wire [4:0] trim_load_index;
  wire access;
  wire xfer;
  wire wr_xfer;
  wire index_ok;
  wire trim_wr_en;
  wire opt_lost;
  wire user_req;
  wire [31:0] status_word;
  wire [2:0] kind_req;
  wire [2:0] kind_dbg;
  wire [2:0] next_grant;
  reg page_zero_erase;
  genvar gi;

  // flash address of each boot step
  function [13:0] step_addr;
    input [5:0] s;
    reg [6:0] off;
    begin
      off = 7'h00;
      if (s == 6'd0) begin
        step_addr = {1'b0, `OPT_PROTECT_ADDR};
      end else if (s == `STEP_OPT_OSC) begin
        step_addr = {1'b0, `OPT_OSC_ADDR};
      end else if (s < `STEP_SERIAL_FIRST) begin
        off = `TRIM_INFO_BASE + {1'b0, s - `STEP_TRIM_FIRST}; // R6
        step_addr = {1'b1, 6'h00, off};
      end else begin
        off = `SERIAL_INFO_BASE + {1'b0, s - `STEP_SERIAL_FIRST};
        step_addr = {1'b1, 6'h00, off};
      end
    end
  endfunction

  // trim index inside the 32-byte window
  function in_trim_window;
    input [7:0] idx;
    begin
      in_trim_window = (idx <= `TRIM_LAST);
    end
  endfunction

  // user request passes only while the write-protect option is 1
  function user_pass;
    input req;
    input [7:0] opt;
    begin
      user_pass = req & opt[`BIT_WRITE_PROTECT];
    end
  endfunction

  // boot loader sequence
  always @* begin
    case (state)
      ST_ISSUE: next_state = ST_WAIT;
      ST_WAIT: next_state = ST_TAKE;
      ST_TAKE: next_state = (step == `STEP_LAST) ? ST_DONE : ST_ISSUE;
      ST_DONE: next_state = ST_DONE;
      default: next_state = ST_ISSUE;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_ISSUE;
      step <= 6'd0;
      flash_rd_en <= 1'b0;
      flash_info_sel <= 1'b0;
      flash_addr <= 13'h0000;
      config_ready <= 1'b0;
    end else begin
      state <= next_state;
      flash_rd_en <= (state == ST_ISSUE);
      if (state == ST_ISSUE) begin
        {flash_info_sel, flash_addr} <= step_addr(step);
      end
      if (state == ST_TAKE && step != `STEP_LAST) begin
        step <= step + 6'd1;
      end
      config_ready <= (next_state == ST_DONE); // R16
    end
  end

  // latched option bytes and serial number
  assign user_req = user_prog_req | user_page_erase_req | user_mass_erase_req;
  assign opt_lost = page_zero_erase | mass_erase_grant; // R1

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_protect <= `ERASED_BYTE;
      opt_osc <= `ERASED_BYTE;
      serial <= 32'h00000000;
    end else if (state == ST_TAKE) begin
      if (step == 6'd0) begin
        opt_protect <= flash_rdata; // R1
      end else if (step == `STEP_OPT_OSC) begin
        opt_osc <= flash_rdata; // R14
      end else if (step >= `STEP_SERIAL_FIRST) begin
        serial <= {serial[23:0], flash_rdata}; // R8
      end
    end else if (opt_lost) begin
      opt_protect <= `ERASED_BYTE; // R1
      opt_osc <= `ERASED_BYTE;
    end
  end

  // working trim copies reload from the info page on every reset
  assign trim_load_en = (state == ST_TAKE) && (step >= `STEP_TRIM_FIRST) &&
    (step < `STEP_SERIAL_FIRST); // R4
  assign trim_load_index = step[4:0] - 5'd2;

  // apb decode
  assign access = psel & penable & config_ready;
  assign xfer = access & pready;
  assign wr_xfer = xfer & pwrite;
  assign index_ok = in_trim_window(trim_index); // R6
  assign trim_wr_en = wr_xfer && (paddr == `REG_TRIM_DATA) && index_ok; // R2

  assign status_word = {26'h0000000, read_protect_honoured, 2'b00,
    ~opt_protect[`BIT_MUST_BE_ONE], blocked, config_ready}; // R15 R11

  trim_store u_trim (
    .pclk(pclk),
    .load_en(trim_load_en),
    .load_index(trim_load_index),
    .load_data(flash_rdata),
    .wr_en(trim_wr_en),
    .wr_index(trim_index[4:0]),
    .wr_data(pwdata[7:0]),
    .rd_index(trim_index[4:0]),
    .rd_data(trim_rd_data)
  ); // R5

  // answer one cycle into the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= access & ~pready;
      if (access & ~pready) begin
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
        case (paddr)
          `REG_TRIM_INDEX: prdata <= {24'h000000, trim_index};
          `REG_TRIM_DATA: prdata <= index_ok ? {24'h000000, trim_rd_data} : 32'h00000000; // R3
          `REG_OPT_PROTECT: prdata <= {24'h000000, opt_protect};
          `REG_OPT_OSC: prdata <= {24'h000000, opt_osc};
          `REG_STATUS: prdata <= status_word;
          `REG_SERIAL: prdata <= serial;
          default: pslverr <= 1'b1;
        endcase
        if (pwrite && paddr != `REG_TRIM_INDEX && paddr != `REG_TRIM_DATA &&
            paddr != `REG_STATUS) begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // trim index register and blocked-request flag
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_index <= `TRIM_INDEX_RESET;
      blocked <= 1'b0;
    end else begin
      if (wr_xfer && paddr == `REG_TRIM_INDEX) begin
        trim_index <= pwdata[7:0]; // R2
      end
      if (config_ready && user_req && !opt_protect[`BIT_WRITE_PROTECT]) begin
        blocked <= 1'b1; // R12
      end else if (wr_xfer && paddr == `REG_STATUS && pwdata[`STAT_BLOCKED]) begin
        blocked <= 1'b0;
      end
    end
  end

  // flash protection gate: program, page erase, mass erase
  assign kind_req = {user_prog_req, user_page_erase_req, user_mass_erase_req};
  assign kind_dbg = {2'b00, debug_mass_erase_req};
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_grant
      assign next_grant[gi] = config_ready &
        (user_pass(kind_req[gi], opt_protect) | kind_dbg[gi]); // R12 R13
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_grant <= 1'b0;
      page_erase_grant <= 1'b0;
      mass_erase_grant <= 1'b0;
      page_zero_erase <= 1'b0;
    end else begin
      prog_grant <= next_grant[2]; // R13
      page_erase_grant <= next_grant[1]; // R13
      mass_erase_grant <= next_grant[0]; // R12
      // page number is only valid beside the request pulse
      page_zero_erase <= next_grant[1] & (erase_page == `PAGE_ZERO); // R1
    end
  end

  // configuration outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brownout_always_on <= 1'b1;
      brownout_enable <= 1'b1;
      code_read_protect <= 1'b1;
      debug_full_access <= 1'b1;
      code_write_protect <= 1'b1;
      crystal_disable_option <= 1'b1;
    end else begin
      brownout_always_on <= opt_protect[`BIT_BO_ALWAYS_ON];
      brownout_enable <= ~(stop_mode & brownout_off_request &
        ~opt_protect[`BIT_BO_ALWAYS_ON]); // R9
      code_read_protect <= opt_protect[`BIT_READ_PROTECT]; // R10
      debug_full_access <= opt_protect[`BIT_READ_PROTECT] | read_protect_honoured; // R15
      code_write_protect <= opt_protect[`BIT_WRITE_PROTECT];
      crystal_disable_option <= opt_osc[`BIT_XTAL_DISABLE]; // R14
    end
  end
endmodule
`default_nettype wire

// ### option_trim_config_checker.sv
// port assertions for the option and trim loader
`timescale 1ns/1ps
`default_nettype none
module option_trim_config_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb and boot
  input wire logic pready,
  input wire logic config_ready,
  // flash gate
  input wire logic user_prog_req,
  input wire logic debug_mass_erase_req,
  input wire logic prog_grant,
  input wire logic mass_erase_grant,
  input wire logic code_write_protect,
  // power and debug
  input wire logic stop_mode,
  input wire logic brownout_off_request,
  input wire logic brownout_always_on,
  input wire logic brownout_enable,
  input wire logic code_read_protect,
  input wire logic read_protect_honoured,
  input wire logic debug_full_access
);
  logic [7:0] cnt;
  always @(posedge pclk or negedge presetn)
    if (!presetn) cnt <= 8'h00;
    else if (cnt != 8'hc8) cnt <= cnt + 8'h01;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready_time; config_ready == (cnt >= 8'h72); endproperty
  a_ready_time: assert property (p_ready_time) else $error("ready cycle");
  property p_no_early; !config_ready |-> !pready; endproperty
  a_no_early: assert property (p_no_early) else $error("early answer");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("long ready");
  property p_wp_block; config_ready && user_prog_req && !code_write_protect |=> !prog_grant;
  endproperty
  a_wp_block: assert property (p_wp_block) else $error("grant when blocked");
  property p_wp_allow; config_ready && user_prog_req && code_write_protect |=> prog_grant;
  endproperty
  a_wp_allow: assert property (p_wp_allow) else $error("no grant");
  property p_dbg_mass; config_ready && debug_mass_erase_req |=> mass_erase_grant; endproperty
  a_dbg_mass: assert property (p_dbg_mass) else $error("debug erase lost");
  property p_bo_off;
    config_ready && stop_mode && brownout_off_request && !brownout_always_on |=> !brownout_enable;
  endproperty
  a_bo_off: assert property (p_bo_off) else $error("brownout kept");
  property p_rp; !code_read_protect && !$past(read_protect_honoured) |-> !debug_full_access;
  endproperty
  a_rp: assert property (p_rp) else $error("debug open");
  c_prog: cover property (prog_grant);
  c_mass: cover property (mass_erase_grant);
  c_bo: cover property (!brownout_enable);
endmodule
`default_nettype wire

// ### flash_model.sv
// flash model answering boot reads
`timescale 1ns/1ps
`default_nettype none
module flash_model (
  // clock
  input wire logic pclk,
  // read port
  input wire logic rd_en,
  input wire logic info_sel,
  input wire logic [12:0] addr,
  output logic [7:0] rdata,
  // option byte 0 content
  input wire logic [7:0] opt0
);
  initial rdata = 8'h00;
  always @(posedge pclk)
    if (!rd_en) rdata <= ~rdata;
    else if (info_sel) rdata <= addr[7:0] ^ 8'ha5;
    else rdata <= addr[0] ? 8'hef : opt0;
endmodule
`default_nettype wire

// ### option_bit_trim_config_tb.sv
// self-checking bench for the option and trim loader
`timescale 1ns/1ps
`default_nettype none
module option_bit_trim_config_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er, pready, pslverr;
  logic stop_mode = 0, bo_req = 0, rph = 0, f_en, f_info, cr, bao, boe, crp, dfa, cwp, xd;
  logic [7:0] paddr = 0, opt0 = 8'hff, f_data, w[32];
  logic [7:0] bad[4] = '{8'h08, 8'h0c, 8'h14, 8'h18};
  logic [31:0] pwdata = 0, prdata, rd;
  logic [12:0] f_addr;
  logic [3:0] rq = 0, pg = 4'h5;
  logic [2:0] g;
  int fail_count = 0, n_tests = 0, i;
  always #5 pclk = ~pclk;
  flash_model u_flash (.pclk, .rd_en(f_en), .info_sel(f_info), .addr(f_addr),
    .rdata(f_data), .opt0);
  option_trim_config u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .flash_rd_en(f_en), .flash_info_sel(f_info),
    .flash_addr(f_addr), .flash_rdata(f_data), .user_prog_req(rq[3]),
    .user_page_erase_req(rq[2]), .erase_page(pg), .user_mass_erase_req(rq[1]),
    .debug_mass_erase_req(rq[0]), .prog_grant(g[2]), .page_erase_grant(g[1]),
    .mass_erase_grant(g[0]), .stop_mode, .brownout_off_request(bo_req),
    .read_protect_honoured(rph), .config_ready(cr), .brownout_always_on(bao),
    .brownout_enable(boe), .code_read_protect(crp), .debug_full_access(dfa),
    .code_write_protect(cwp), .crystal_disable_option(xd));
  task chk(input logic [31:0] s, e, input string nm);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", nm, e, s);
    end
  endtask
  function automatic logic [7:0] info_byte(input logic [7:0] a);
    return a ^ 8'ha5;
  endfunction
  task results;
    if (fail_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(pready), 32'h1, "pready");
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task trim_rd(input logic [7:0] x, e);
    apb(1, 8'h00, {24'h0, x});
    apb(0, 8'h04, 32'h0);
    chk(rd, {24'h0, e}, "trim");
  endtask
  task gate(input logic [3:0] r, input logic [2:0] e, input logic [3:0] p = 4'h5);
    rq <= r;
    pg <= p;
    @(posedge pclk);
    rq <= 0;
    pg <= ~p;
    @(posedge pclk);
    chk({29'h0, g}, {29'h0, e}, "grant");
  endtask
  task rdopt(input logic [7:0] a, b);
    apb(0, 8'h08, 32'h0);
    chk(rd, {24'h0, a}, "opt0");
    apb(0, 8'h0c, 32'h0);
    chk(rd, {24'h0, b}, "opt1");
    chk({28'h0, bao, crp, cwp, xd}, {28'h0, a[3], a[2], a[0], b[4]}, "opts");
  endtask
  task boot(input logic [7:0] o);
    opt0 <= o;
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, 8'h10, 32'h0);
    chk(rd, 32'h1, "status");
    rdopt(o, 8'hef);
  endtask
  initial begin
    i = $urandom(80398);
    foreach (w[k]) w[k] = info_byte(8'h20 + k[7:0]);
    boot(8'hff);
    for (int k = 0; k < 6; k++) begin
      i = k < 2 ? k * 31 : $urandom % 32;
      trim_rd(i[7:0], w[i]);
      w[i] = 8'($urandom);
      apb(1, 8'h04, {24'h0, w[i]});
      trim_rd(i[7:0], w[i]);
    end
    i = 32 + $urandom % 224;
    trim_rd(i[7:0], 8'h00);
    apb(1, 8'h04, {24'h0, ~w[i % 32]});
    trim_rd(8'(i % 32), w[i % 32]);
    apb(0, 8'h14, 32'h0);
    i = {info_byte(8'h7c), info_byte(8'h7d), info_byte(8'h7e), info_byte(8'h7f)};
    chk(rd, i, "serial");
    foreach (bad[k]) begin
      apb(1, bad[k], 32'h0);
      chk(32'(er), 32'h1, "error");
    end
    rdopt(8'hff, 8'hef);
    gate(4'h8, 3'h4);
    gate(4'h4, 3'h2);
    rdopt(8'hff, 8'hef);
    gate(4'h4, 3'h2, 4'h0);
    rdopt(8'hff, 8'hff);
    rph <= 1;
    apb(0, 8'h10, 32'h0);
    chk(rd, 32'h21, "status");
    rph <= 0;
    boot(8'hf2);
    trim_rd(8'h00, info_byte(8'h20));
    gate(4'h8, 3'h0);
    gate(4'h2, 3'h0);
    apb(0, 8'h10, 32'h0);
    chk(rd, 32'h3, "status");
    apb(1, 8'h10, 32'h2);
    apb(0, 8'h10, 32'h0);
    chk(rd, 32'h1, "clear");
    chk(32'(dfa), 32'h0, "debug");
    stop_mode <= 1;
    bo_req <= 1;
    repeat (2) @(posedge pclk);
    chk(32'(boe), 32'h0, "brownout");
    stop_mode <= 0;
    bo_req <= 0;
    gate(4'h1, 3'h1);
    rdopt(8'hff, 8'hff);
    results;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    results;
  end
endmodule
bind option_trim_config option_trim_config_checker u_chk (.pclk, .presetn, .pready,
  .config_ready, .user_prog_req, .debug_mass_erase_req, .prog_grant, .mass_erase_grant,
  .code_write_protect, .stop_mode, .brownout_off_request, .brownout_always_on,
  .brownout_enable, .code_read_protect, .read_protect_honoured, .debug_full_access);
`default_nettype wire
